// [pxe_regs.vh]
// constants for the eight-output i2c port expander
`ifndef PXE_REGS_VH
`define PXE_REGS_VH
`define PXE_ADDR_FIXED 3'h5
`define PXE_SEL_GND 2'h0
`define PXE_SEL_VDD 2'h1
`define PXE_SEL_SDA 2'h2
`define PXE_SEL_SCL 2'h3
`define PXE_SYNC_STAGES 2
`define PXE_CLK_NS 25
`define PXE_SETTLE_NS 200
`define PXE_SETTLE_CYC ((`PXE_SETTLE_NS + `PXE_CLK_NS - 1) / `PXE_CLK_NS)
`endif

// [pxe_expander.v]
// i2c slave driving eight push-pull output ports
//
// What this block does
// - answers addresses 101 plus four selected bits
// - address select re-evaluated every bus transmission
// - each select pin: low, high, sda, scl
// - lower ports from low select, upper from high
// - low connection gives low, others give high
// - before first transmission sda/scl read as levels
// - only supply/ground selections are safe at power-up
// - clear input aborts transfer, back to idle
// - clear input leaves output latch unchanged
// - read returns actual pin levels
// - each write byte updates all ports together
// - idle interface means standby, no command
// - scl is input only
// - sda driven only by open-drain pull-down
// - start is sda fall while scl high
// - stop is sda rise while scl high
// - idle bus keeps both lines high
// - one bit per clock, stable while high
// - receiver pulls sda low on ninth pulse
// - direction bit low write, high read
// - read samples pins each ack, sends next
// - write acks each byte, loads ports
`timescale 1ns/10ps
`include "pxe_regs.vh"
module pxe_expander #(
    parameter [63:0] ADDR_LUT = 64'hFEDCBA9876543210
) (
    clk_sys,
    rst,
    scl_in,
    sda_in,
    sda_out,
    sda_oe_n,
    clear_n,
    addr_sel_low_group,
    addr_sel_high_group,
    port_pins_in,
    output_port_pins,
    busy,
    standby
);
input wire clk_sys;
input wire rst;
input wire scl_in;
input wire sda_in;
output wire sda_out;
output wire sda_oe_n;
input wire clear_n;
input wire addr_sel_low_group;
input wire addr_sel_high_group;
input wire [7:0] port_pins_in;
output reg [7:0] output_port_pins;
output wire busy;
output wire standby;

// ************************************************
// synchronisers
// ************************************************
reg [1:0] scl_s_q;
reg [1:0] sda_s_q;
reg [1:0] clr_s_q;
reg [1:0] a0_s_q;
reg [1:0] a2_s_q;
reg [7:0] pin_s1_q;
reg [7:0] pin_s2_q;
reg scl_p_q;
reg sda_p_q;
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        scl_s_q <= 2'h3;
        sda_s_q <= 2'h3;
        clr_s_q <= 2'h3;
        a0_s_q <= 2'h3;
        a2_s_q <= 2'h3;
        pin_s1_q <= 8'h00;
        pin_s2_q <= 8'h00;
        scl_p_q <= 1'b1;
        sda_p_q <= 1'b1;
    end else begin
        scl_s_q <= {scl_s_q[0], scl_in};
        sda_s_q <= {sda_s_q[0], sda_in};
        clr_s_q <= {clr_s_q[0], clear_n};
        a0_s_q <= {a0_s_q[0], addr_sel_low_group};
        a2_s_q <= {a2_s_q[0], addr_sel_high_group};
        pin_s1_q <= port_pins_in;
        pin_s2_q <= pin_s1_q;
        scl_p_q <= scl_s_q[1];
        sda_p_q <= sda_s_q[1];
    end
end
wire scl = scl_s_q[1];
wire sda = sda_s_q[1];
wire a0 = a0_s_q[1];
wire a2 = a2_s_q[1];
wire clr_act = ~clr_s_q[1];
wire scl_rise = scl & ~scl_p_q;
wire scl_fall = ~scl & scl_p_q;
wire start_det = scl & scl_p_q & sda_p_q & ~sda;
wire stop_det = scl & scl_p_q & ~sda_p_q & sda;

// engine state, also read by the select classifier below
localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_ADDR = 3'h1;
localparam [2:0] ST_AACK = 3'h2;
localparam [2:0] ST_WR = 3'h3;
localparam [2:0] ST_WACK = 3'h4;
localparam [2:0] ST_RD = 3'h5;
localparam [2:0] ST_RACK = 3'h6;
reg [2:0] st_q;
reg [3:0] bit_q;
reg [7:0] sh_q;
reg rd_q;
reg pull_q;
reg [7:0] tx_q;
reg pwr_q;

// ************************************************
// four-level select detection
// ************************************************
reg a0_hi_q;
reg a0_lo_q;
reg a0_nsda_q;
reg a0_nscl_q;
reg a2_hi_q;
reg a2_lo_q;
reg a2_nsda_q;
reg a2_nscl_q;
reg [1:0] sel0_q;
reg [1:0] sel2_q;
reg xfer_q;
reg seen_q;
function [1:0] pxe_class;
    input hi, lo, nsda, nscl;
    begin
        if (!hi)
            pxe_class = `PXE_SEL_GND;
        else if (!lo)
            pxe_class = `PXE_SEL_VDD;
        else if (!nsda)
            pxe_class = `PXE_SEL_SDA;
        else if (!nscl)
            pxe_class = `PXE_SEL_SCL;
        else
            pxe_class = `PXE_SEL_VDD;
    end
endfunction
// per transmission: seen high, seen low, seen differing from each line
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        a0_hi_q <= 1'b0;
        a0_lo_q <= 1'b0;
        a0_nsda_q <= 1'b0;
        a0_nscl_q <= 1'b0;
        a2_hi_q <= 1'b0;
        a2_lo_q <= 1'b0;
        a2_nsda_q <= 1'b0;
        a2_nscl_q <= 1'b0;
        sel0_q <= `PXE_SEL_VDD;
        sel2_q <= `PXE_SEL_VDD;
        seen_q <= 1'b0;
    end else if (start_det) begin
        a0_hi_q <= a0;
        a0_lo_q <= ~a0;
        a0_nsda_q <= 1'b0;
        a0_nscl_q <= 1'b0;
        a2_hi_q <= a2;
        a2_lo_q <= ~a2;
        a2_nsda_q <= 1'b0;
        a2_nscl_q <= 1'b0;
    end else if (xfer_q) begin
        a0_hi_q <= a0_hi_q | a0;
        a0_lo_q <= a0_lo_q | ~a0;
        a0_nsda_q <= a0_nsda_q | (a0 ^ sda);
        a0_nscl_q <= a0_nscl_q | (a0 ^ scl);
        a2_hi_q <= a2_hi_q | a2;
        a2_lo_q <= a2_lo_q | ~a2;
        a2_nsda_q <= a2_nsda_q | (a2 ^ sda);
        a2_nscl_q <= a2_nscl_q | (a2 ^ scl);
        // classify once address byte is in, before compare
        if (bit_q == 4'h7 && scl_rise && st_q == ST_ADDR) begin
            sel0_q <= pxe_class(a0_hi_q, a0_lo_q, a0_nsda_q, a0_nscl_q);
            sel2_q <= pxe_class(a2_hi_q, a2_lo_q, a2_nsda_q, a2_nscl_q);
            seen_q <= 1'b1;
        end
    end else if (!seen_q) begin
        sel0_q <= a0 ? `PXE_SEL_VDD : `PXE_SEL_GND;
        sel2_q <= a2 ? `PXE_SEL_VDD : `PXE_SEL_GND;
    end
end
wire [3:0] lut_idx = {sel2_q, sel0_q};
wire [3:0] addr_low = ADDR_LUT[{lut_idx, 2'h0} +: 4];
wire [6:0] my_addr = {`PXE_ADDR_FIXED, addr_low};

// ************************************************
// protocol engine
// ************************************************
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        st_q <= ST_IDLE;
        bit_q <= 4'h0;
        sh_q <= 8'h00;
        rd_q <= 1'b0;
        pull_q <= 1'b0;
        tx_q <= 8'h00;
        xfer_q <= 1'b0;
        pwr_q <= 1'b1;
        output_port_pins <= 8'h00;
    end else begin
        // defaults follow the held select class, not the toggling lines
        if (pwr_q) begin
            output_port_pins[7:4] <= {4{sel2_q != `PXE_SEL_GND}};
            output_port_pins[3:0] <= {4{sel0_q != `PXE_SEL_GND}};
        end
        if (clr_act || stop_det) begin
            st_q <= ST_IDLE;
            pull_q <= 1'b0;
            xfer_q <= 1'b0;
        end else if (start_det) begin
            st_q <= ST_ADDR;
            bit_q <= 4'h0;
            pull_q <= 1'b0;
            xfer_q <= 1'b1;
        end else begin
            case (st_q)
            ST_ADDR, ST_WR: begin
                if (scl_rise) begin
                    sh_q <= {sh_q[6:0], sda};
                    bit_q <= bit_q + 4'h1;
                end
                if (scl_fall && bit_q == 4'h8) begin
                    bit_q <= 4'h0;
                    if (st_q == ST_WR) begin
                        pull_q <= 1'b1;
                        st_q <= ST_WACK;
                    end else if (sh_q[7:1] == my_addr) begin
                        rd_q <= sh_q[0];
                        pull_q <= 1'b1;
                        st_q <= ST_AACK;
                    end else begin
                        st_q <= ST_IDLE;
                        xfer_q <= 1'b1;
                    end
                end
            end
            ST_AACK, ST_WACK, ST_RACK: begin
                if (scl_rise && st_q != ST_WACK) begin
                    tx_q <= pin_s2_q;
                end
                if (scl_rise && st_q == ST_WACK) begin
                    output_port_pins <= sh_q;
                    pwr_q <= 1'b0;
                end
                if (scl_rise && st_q == ST_RACK && sda) begin
                    st_q <= ST_IDLE; // master nack ends read
                end
                if (scl_fall) begin
                    pull_q <= 1'b0;
                    if (rd_q) begin
                        st_q <= ST_RD;
                        pull_q <= ~tx_q[7];
                    end else begin
                        st_q <= ST_WR;
                    end
                end
            end
            ST_RD: begin
                if (scl_fall) begin
                    bit_q <= bit_q + 4'h1;
                    tx_q <= {tx_q[6:0], 1'b1};
                    if (bit_q == 4'h7) begin
                        bit_q <= 4'h0;
                        pull_q <= 1'b0;
                        st_q <= ST_RACK;
                    end else begin
                        pull_q <= ~tx_q[6];
                    end
                end
            end
            default: begin
                st_q <= ST_IDLE;
            end
            endcase
        end
    end
end
// scl has no output at all
assign sda_out = 1'b0;
assign sda_oe_n = ~pull_q;
assign busy = (st_q != ST_IDLE);
assign standby = ~xfer_q;
endmodule

// [pxe_properties.sv]
// concurrent checks on the port expander pins
`timescale 1ns/10ps
module pxe_checker (
    input wire clk_sys,
    input wire rst,
    input wire scl_in,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe_n,
    input wire clear_n,
    input wire [7:0] output_port_pins,
    input wire busy,
    input wire standby
);
// ****************
// properties
// ****************
default clocking cb @(posedge clk_sys); endclocking
default disable iff (rst);
property p_od; sda_out == 1'h0; endproperty
a_od: assert property (p_od) else $error("sda driven high");
property p_idle; standby |-> sda_oe_n; endproperty
a_idle: assert property (p_idle) else $error("idle pull");
property p_sby; busy [*2] |-> !standby; endproperty
a_sby: assert property (p_sby) else $error("standby busy");
property p_clr; !clear_n [*4] |-> !busy && sda_oe_n; endproperty
a_clr: assert property (p_clr) else $error("clear no abort");
property p_keep; !clear_n && !$past(clear_n) |-> $stable(output_port_pins);
endproperty
a_keep: assert property (p_keep) else $error("clear hit latch");
property p_hold; $changed(sda_oe_n) |-> !scl_in; endproperty
a_hold: assert property (p_hold) else $error("sda moved high");
property p_ack; !sda_oe_n |-> busy; endproperty
a_ack: assert property (p_ack) else $error("pull while idle");
property p_stop; scl_in && $rose(sda_in) |-> ##[1:8] standby; endproperty
a_stop: assert property (p_stop) else $error("stop missed");
c_ack: cover property ($fell(sda_oe_n));
c_wr: cover property (!standby ##1 $changed(output_port_pins));
c_clr: cover property (!clear_n && busy);
endmodule
bind pxe_expander pxe_checker u_chk (.clk_sys(clk_sys), .rst(rst),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .clear_n(clear_n),
    .output_port_pins(output_port_pins), .busy(busy), .standby(standby));

// [pxe_master.sv]
// i2c bus master model for the port expander
`timescale 1ns/10ps
module pxe_master (
    input wire clk_sys,
    input wire sda,
    output logic scl = 1'h1,
    output logic sda_drv = 1'h1
);
// ****************
// bus tasks
// ****************
task drv(input logic c, input logic d, input int n);
    scl = c;
    sda_drv = d;
    repeat (n) @(posedge clk_sys);
    #2;
endtask
task start_c;
    drv(1'h0, sda_drv, 1);
    drv(1'h0, 1'h1, 3);
    drv(1'h1, 1'h1, 3);
    drv(1'h1, 1'h0, 3);
endtask
task stop_c;
    drv(1'h0, sda_drv, 1);
    drv(1'h0, 1'h0, 4);
    drv(1'h1, 1'h0, 3);
    drv(1'h1, 1'h1, 4);
endtask
// data moves only while scl low
task bit_x(input logic b, output logic r);
    drv(1'h0, sda_drv, 1);
    drv(1'h0, b, 4);
    drv(1'h1, b, 3);
    r = sda;
endtask
task byte_x(input logic [7:0] d, input logic am, output logic [7:0] q,
    output logic ack);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(am, ack);
endtask
endmodule

// [pxe_expander_tb.sv]
// self-checking bench for the port expander
`timescale 1ns/10ps
module pxe_expander_tb;
logic clk_sys = 1'h0, rst = 1'h1, clear_n = 1'h1, ak;
logic [1:0] s_lo = 2'h0, s_hi = 2'h0;
logic [7:0] frc = 8'h00, rd, rd2, last, d;
wire scl, sda_m, sda_oe_n, sda_out, busy, standby;
wire [7:0] pins;
wire sda = sda_m & (sda_oe_n | sda_out);
wire sel_l = s_lo[1] ? (s_lo[0] ? scl : sda) : s_lo[0];
wire sel_h = s_hi[1] ? (s_hi[0] ? scl : sda) : s_hi[0];
int num_errors = 0, total_checks = 0, cyc = 0;
always #12.5 clk_sys = ~clk_sys;
pxe_master u_mst (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_drv(sda_m));
pxe_expander u_dut (.clk_sys(clk_sys), .rst(rst), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .clear_n(clear_n), .addr_sel_low_group(sel_l),
    .addr_sel_high_group(sel_h), .port_pins_in(pins ^ frc),
    .output_port_pins(pins), .busy(busy), .standby(standby));
// ****************
// helpers and scenarios
// ****************
task tally_and_finish;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
endtask
always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
        num_errors++;
        tally_and_finish;
    end
end
task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
        num_errors++;
        $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
endtask
task do_reset(input logic [1:0] lo, input logic [1:0] hi);
    s_lo = lo;
    s_hi = hi;
    rst = 1'h1;
    u_mst.drv(1'h1, 1'h1, 12);
    rst = 1'h0;
    u_mst.drv(1'h1, 1'h1, 10);
endtask
task xfer(input logic [6:0] a, input logic rw);
    u_mst.start_c();
    u_mst.byte_x({a, rw}, 1'h1, rd, ak);
endtask
task t_powerup;
    do_reset(2'h0, 2'h1);
    chk("power-up", 8'hF0, pins);
    do_reset(2'h2, 2'h0);
    chk("power-up", 8'h0F, pins);
endtask
task t_addr;
    for (int i = 0; i < 16; i++) begin
        s_hi = i[3:2];
        s_lo = i[1:0];
        xfer({3'h6, i[3:0]}, 1'h0);
        u_mst.stop_c();
        chk("foreign ack", 8'h01, {7'h00, ak});
        xfer({3'h5, i[3:0]}, 1'h0);
        chk("addr ack", 8'h00, {7'h00, ak});
        d = i[7:0] * 8'h11 ^ 8'h5A;
        u_mst.byte_x(d, 1'h1, rd, ak);
        chk("write 1", d, pins);
        u_mst.byte_x(~d, 1'h1, rd, ak);
        chk("write 2", ~d, pins);
        chk("data ack", 8'h00, {7'h00, ak});
        last = ~d;
        u_mst.stop_c();
        chk("standby", 8'h01, {7'h00, standby});
    end
endtask
task t_read;
    frc = 8'h0C;
    xfer(7'h5F, 1'h1);
    chk("read addr ack", 8'h00, {7'h00, ak});
    for (int i = 7; i >= 0; i--) u_mst.bit_x(1'h1, rd[i]);
    frc = 8'h81;
    u_mst.bit_x(1'h0, ak);
    u_mst.byte_x(8'hFF, 1'h1, rd2, ak);
    u_mst.stop_c();
    chk("read 1", last ^ 8'h0C, rd);
    chk("read 2", last ^ 8'h81, rd2);
    frc = 8'h00;
endtask
task t_clear;
    xfer(7'h5F, 1'h0);
    chk("clear addr ack", 8'h00, {7'h00, ak});
    for (int i = 0; i < 8; i++) u_mst.bit_x(1'h0, ak);
    u_mst.drv(1'h0, 1'h1, 5);
    chk("ack pull", 8'h00, {7'h00, sda_oe_n});
    clear_n = 1'h0;
    u_mst.drv(1'h0, 1'h1, 10);
    chk("clear sda", 8'h01, {7'h00, sda_oe_n});
    chk("clear latch", last, pins);
    clear_n = 1'h1;
    u_mst.drv(1'h1, 1'h1, 3);
    chk("after clear", 8'h01, {7'h00, sda});
    u_mst.stop_c();
    chk("clear latch", last, pins);
endtask
initial begin
    t_powerup;
    t_addr;
    t_read;
    t_clear;
    tally_and_finish;
end
endmodule
